// ===== verilog/crs_regset.sv
// cpu register set with banked registers, flags, memory decode and axi4-lite access
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`include "crs_defs.svh"
`default_nettype none
module crs_regset
  import crs_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // core register write port
  input wire logic i_wr_en,
  input wire logic [3:0] i_wr_sel,
  input wire crs_size_type i_wr_size,
  input wire logic [31:0] i_wr_data,
  // core register read port
  input wire logic [3:0] i_rd_sel,
  input wire crs_size_type i_rd_size,
  output logic [31:0] o_rd_data,
  // alu flag update
  input wire logic i_alu_done,
  input wire logic [31:0] i_alu_result,
  input wire logic i_alu_long,
  input wire logic i_alu_carry,
  input wire logic i_alu_ovf,
  input wire logic [3:0] i_alu_mask,
  // instruction pointer control
  input wire logic i_ip_load,
  input wire logic [19:0] i_ip_value,
  input wire logic [2:0] i_ip_step,
  // state seen by the sequencer
  output logic [19:0] o_instr_ptr,
  output logic [19:0] o_vector_base,
  output logic [15:0] o_active_sp,
  output logic [10:0] o_flags,
  // memory decode
  input wire logic [19:0] i_mem_addr,
  output crs_region_type o_mem_region,
  // axi4-lite slave
  input wire logic [`CRS_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`CRS_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ----------------------------------------------------------------
  // state and helper functions
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0][6:0][15:0] gpr; // bank, data0..3 addr0..1 frame
    logic [15:0] static_base;
    logic [19:0] vector_table_base;
    logic [19:0] instr_pointer;
    logic [15:0] user_stack_ptr;
    logic [15:0] irq_stack_ptr;
    logic [10:0] cpu_flags;
    logic [15:0] active_sp; // registered copy for the output
    logic [31:0] rd_data;
    crs_region_type region;
    logic aw_held; // write address captured
    logic w_held; // write data captured
    logic [3:0] wr_idx;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    crs_rd_state_type rd_state;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } crs_state_type;
  crs_state_type st_q; // registered state
  crs_state_type st_d; // next state
  // read a register at the requested size, bytes and words zero-extended, longs paired high:low
  function automatic logic [31:0] crs_read(input crs_state_type s, input logic [3:0] sel,
                                           input crs_size_type sz);
    logic bk;
    logic [31:0] v;
    bk = s.cpu_flags[`CRS_FLG_B];
    v = 32'h0000_0000;
    case (sel)
      `CRS_IDX_DATA0, `CRS_IDX_DATA1, `CRS_IDX_DATA2, `CRS_IDX_DATA3,
      `CRS_IDX_ADDR0, `CRS_IDX_ADDR1, `CRS_IDX_FRAME:
      begin
        v = {16'h0000, s.gpr[bk][sel[2:0]]};
        if (sz == CRS_SZ_LONG && sel <= `CRS_IDX_DATA1)
          v = {s.gpr[bk][sel[2:0] + 3'h2], s.gpr[bk][sel[2:0]]};
        else if (sz == CRS_SZ_LONG && sel == `CRS_IDX_ADDR0)
          v = {s.gpr[bk][`CRS_IDX_ADDR1], s.gpr[bk][`CRS_IDX_ADDR0]};
        else if (sz == CRS_SZ_LOW && sel <= `CRS_IDX_DATA1)
          v = {24'h000000, s.gpr[bk][sel[2:0]][7:0]};
        else if (sz == CRS_SZ_HIGH && sel <= `CRS_IDX_DATA1)
          v = {24'h000000, s.gpr[bk][sel[2:0]][15:8]};
      end
      `CRS_IDX_STATIC: v = {16'h0000, s.static_base};
      `CRS_IDX_VECTB: v = {12'h000, s.vector_table_base};
      `CRS_IDX_IPTR: v = {12'h000, s.instr_pointer};
      `CRS_IDX_USP: v = {16'h0000, s.user_stack_ptr};
      `CRS_IDX_ISP: v = {16'h0000, s.irq_stack_ptr};
      `CRS_IDX_FLAGS: v = {21'h000000, s.cpu_flags};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction
  // merge 32-bit data into a register under a 4-bit lane mask
  function automatic logic [31:0] crs_merge(input logic [31:0] old, input logic [31:0] val,
                                            input logic [3:0] lanes);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (lanes[i])
        r[i*8 +: 8] = val[i*8 +: 8];
    end
    return r;
  endfunction
  // write a register; lanes pick bytes, long writes reach the pair partner
  function automatic crs_state_type crs_write(input crs_state_type s, input logic [3:0] sel,
                                              input crs_size_type sz, input logic [31:0] val,
                                              input logic [3:0] lanes);
    crs_state_type r;
    logic bk;
    logic [31:0] m;
    r = s;
    bk = s.cpu_flags[`CRS_FLG_B];
    m = crs_merge(crs_read(s, sel, CRS_SZ_LONG), val, lanes);
    case (sel)
      `CRS_IDX_DATA0, `CRS_IDX_DATA1, `CRS_IDX_DATA2, `CRS_IDX_DATA3,
      `CRS_IDX_ADDR0, `CRS_IDX_ADDR1, `CRS_IDX_FRAME:
      begin
        if (sz == CRS_SZ_LOW && sel <= `CRS_IDX_DATA1)
          r.gpr[bk][sel[2:0]][7:0] = val[7:0];
        else if (sz == CRS_SZ_HIGH && sel <= `CRS_IDX_DATA1)
          r.gpr[bk][sel[2:0]][15:8] = val[7:0];
        else
          r.gpr[bk][sel[2:0]] = m[15:0];
        if (sz == CRS_SZ_LONG && sel <= `CRS_IDX_DATA1)
          r.gpr[bk][sel[2:0] + 3'h2] = m[31:16];
        if (sz == CRS_SZ_LONG && sel == `CRS_IDX_ADDR0)
          r.gpr[bk][`CRS_IDX_ADDR1] = m[31:16];
      end
      `CRS_IDX_STATIC: r.static_base = m[15:0];
      `CRS_IDX_VECTB: r.vector_table_base = m[19:0];
      `CRS_IDX_IPTR: r.instr_pointer = m[19:0];
      `CRS_IDX_USP: r.user_stack_ptr = m[15:0];
      `CRS_IDX_ISP: r.irq_stack_ptr = m[15:0];
      `CRS_IDX_FLAGS: r.cpu_flags = m[10:0];
      default: r = s;
    endcase
    return r;
  endfunction
  // classify an address into its region; the vectors win over the rom they sit at the top of
  function automatic crs_region_type crs_decode(input logic [19:0] a);
    crs_region_type g;
    if (a <= `CRS_SFR0_HI || (a >= `CRS_SFR1_LO && a <= `CRS_SFR1_HI))
      g = CRS_RG_SFR;
    else if (a >= `CRS_RAM_LO && a <= `CRS_RAM_HI)
      g = CRS_RG_RAM;
    else if (a >= `CRS_DFL_LO && a <= `CRS_DFL_HI)
      g = CRS_RG_DFL;
    else if (a >= `CRS_VEC_LO && a <= `CRS_ROM_HI)
      g = CRS_RG_VEC;
    else if (a >= `CRS_ROM_LO && a <= `CRS_ROM_HI)
      g = CRS_RG_ROM;
    else if (a > `CRS_ROM_HI)
      g = CRS_RG_EXT;
    else
      g = CRS_RG_RSV;
    return g;
  endfunction
  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // core traffic first, then the bus write, so software has the last word
  always_comb
  begin
    logic [31:0] res;
    logic zres;
    logic nres;
    logic [3:0] lanes;
    st_d = st_q;
    res = i_alu_long ? i_alu_result : {16'h0000, i_alu_result[15:0]};
    zres = (res == 32'h0000_0000);
    nres = i_alu_long ? i_alu_result[31] : i_alu_result[15];
    lanes = (i_wr_size == CRS_SZ_LONG) ? 4'hF : 4'h3;
    // instruction pointer advance or jump
    if (i_ip_load)
      st_d.instr_pointer = i_ip_value;
    else
      st_d.instr_pointer = st_q.instr_pointer + {17'h00000, i_ip_step};
    // operand writeback from the core
    if (i_wr_en)
      st_d = crs_write(st_d, i_wr_sel, i_wr_size, i_wr_data, lanes);
    // only flags named in the mask change
    if (i_alu_done)
    begin
      if (i_alu_mask[0])
        st_d.cpu_flags[`CRS_FLG_C] = i_alu_carry;
      if (i_alu_mask[1])
        st_d.cpu_flags[`CRS_FLG_Z] = zres;
      if (i_alu_mask[2])
        st_d.cpu_flags[`CRS_FLG_S] = nres;
      if (i_alu_mask[3])
        st_d.cpu_flags[`CRS_FLG_O] = i_alu_ovf;
    end
    // axi write: capture address and data in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      st_d.aw_held = 1'b1;
      st_d.wr_idx = s_axi_awaddr[`CRS_AXI_AW-1:2];
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      st_d.w_held = 1'b1;
      st_d.wdata = s_axi_wdata;
      st_d.wstrb = s_axi_wstrb;
    end
    // both halves present: commit and answer
    if (st_q.aw_held && st_q.w_held && !st_q.bvalid)
    begin
      st_d.aw_held = 1'b0;
      st_d.w_held = 1'b0;
      st_d.bvalid = 1'b1;
      if (st_q.wr_idx <= `CRS_IDX_LAST)
      begin
        st_d = crs_write(st_d, st_q.wr_idx, CRS_SZ_WORD, st_q.wdata, st_q.wstrb);
        st_d.bresp = `CRS_RESP_OKAY;
      end
      else
        st_d.bresp = `CRS_RESP_SLVERR; // unmapped word
    end
    if (st_q.bvalid && s_axi_bready)
      st_d.bvalid = 1'b0;
    // axi read channel
    case (st_q.rd_state)
      CRS_RD_IDLE:
      begin
        if (s_axi_arvalid)
        begin
          st_d.rdata = crs_read(st_q, s_axi_araddr[`CRS_AXI_AW-1:2], CRS_SZ_WORD);
          st_d.rresp = (s_axi_araddr[`CRS_AXI_AW-1:2] <= `CRS_IDX_LAST) ?
                       `CRS_RESP_OKAY : `CRS_RESP_SLVERR;
          st_d.rd_state = CRS_RD_DATA;
        end
      end
      CRS_RD_DATA:
      begin
        if (s_axi_rready)
          st_d.rd_state = CRS_RD_IDLE;
      end
      default: st_d.rd_state = CRS_RD_IDLE;
    endcase
    // registered views: active stack from the next state so it matches the flops, read data from the current state
    st_d.active_sp = st_d.cpu_flags[`CRS_FLG_U] ? st_d.irq_stack_ptr
                                                : st_d.user_stack_ptr;
    st_d.rd_data = crs_read(st_q, i_rd_sel, i_rd_size);
    st_d.region = crs_decode(i_mem_addr);
  end
  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_q <= '0;
      st_q.cpu_flags <= `CRS_FLG_RESET;
      st_q.vector_table_base <= `CRS_VECTB_RESET;
      st_q.instr_pointer <= `CRS_IPTR_RESET;
      st_q.region <= CRS_RG_SFR;
      st_q.rd_state <= CRS_RD_IDLE;
    end
    else
      st_q <= st_d;
  end
  // outputs, all taken from the state register
  assign o_rd_data = st_q.rd_data;
  assign o_instr_ptr = st_q.instr_pointer;
  assign o_vector_base = st_q.vector_table_base;
  assign o_active_sp = st_q.active_sp;
  assign o_flags = st_q.cpu_flags;
  assign o_mem_region = st_q.region;
  // ready held low while a captured half waits, giving back-pressure
  assign s_axi_awready = !st_q.aw_held;
  assign s_axi_wready = !st_q.w_held;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = (st_q.rd_state == CRS_RD_IDLE);
  assign s_axi_rvalid = (st_q.rd_state == CRS_RD_DATA);
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking crs_cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);
  zero_flag_a: assert property (i_alu_done && i_alu_mask[1] && !i_alu_long
    && i_alu_result[15:0] == 16'h0000 |=> o_flags[`CRS_FLG_Z])
    else $error("zero flag not set on zero result");
  sign_flag_a: assert property (i_alu_done && i_alu_mask[2] && i_alu_long
    |=> o_flags[`CRS_FLG_S] == $past(i_alu_result[31]))
    else $error("sign flag wrong for long result");
  carry_flag_a: assert property (i_alu_done && i_alu_mask[0]
    && !(s_axi_awready == 1'b0 && s_axi_wready == 1'b0)
    |=> o_flags[`CRS_FLG_C] == $past(i_alu_carry))
    else $error("carry flag did not follow alu");
  flags_keep_a: assert property (!i_alu_done && !i_wr_en && !(st_q.aw_held && st_q.w_held)
    |=> $stable(o_flags))
    else $error("flags changed without cause");
  stack_sel_a: assert property (##1 o_active_sp == (o_flags[`CRS_FLG_U] ?
    st_q.irq_stack_ptr : st_q.user_stack_ptr))
    else $error("active stack pointer mismatch");
  ip_step_a: assert property (!i_ip_load && !i_wr_en && !(st_q.aw_held && st_q.w_held)
    |=> o_instr_ptr == $past(o_instr_ptr) + {17'h00000, $past(i_ip_step)})
    else $error("instruction pointer did not advance");
  vec_region_a: assert property (i_mem_addr >= `CRS_VEC_LO
    && i_mem_addr <= `CRS_ROM_HI |=> o_mem_region == CRS_RG_VEC)
    else $error("vector table not decoded");
  sfr_region_a: assert property (i_mem_addr >= `CRS_SFR1_LO
    && i_mem_addr <= `CRS_SFR1_HI |=> o_mem_region == CRS_RG_SFR)
    else $error("sfr window not decoded");
  byte_keep_a: assert property (i_wr_en && i_wr_size == CRS_SZ_LOW
    && i_wr_sel == `CRS_IDX_DATA0 && !st_q.aw_held && !i_alu_done
    |=> st_q.gpr[o_flags[`CRS_FLG_B]][0][15:8]
        == $past(st_q.gpr[o_flags[`CRS_FLG_B]][0][15:8]))
    else $error("byte write disturbed upper half");
  resp_hold_a: assert property (s_axi_bvalid |=> s_axi_bvalid == !$past(s_axi_bready))
    else $error("write response dropped or held too long");
  long_wr_c: cover property (i_wr_en && i_wr_size == CRS_SZ_LONG);
  bank_sw_c: cover property (o_flags[`CRS_FLG_B] ##1 !o_flags[`CRS_FLG_B]);
  axi_wr_c: cover property (s_axi_bvalid && s_axi_bready);
  axi_rd_c: cover property (s_axi_rvalid && s_axi_rready);
endmodule
`default_nettype wire

// ===== common/crs_defs.svh
// constants for the cpu register set and memory map block
`ifndef CRS_DEFS_SVH
`define CRS_DEFS_SVH

// ----------------------------------------------------------------
// register index / axi word offsets
// ----------------------------------------------------------------
`define CRS_IDX_DATA0 4'h0
`define CRS_IDX_DATA1 4'h1
`define CRS_IDX_DATA2 4'h2
`define CRS_IDX_DATA3 4'h3
`define CRS_IDX_ADDR0 4'h4
`define CRS_IDX_ADDR1 4'h5
`define CRS_IDX_FRAME 4'h6
`define CRS_IDX_STATIC 4'h7
`define CRS_IDX_VECTB 4'h8
`define CRS_IDX_IPTR 4'h9
`define CRS_IDX_USP 4'hA
`define CRS_IDX_ISP 4'hB
`define CRS_IDX_FLAGS 4'hC
`define CRS_IDX_LAST 4'hC
`define CRS_AXI_AW 6

// ----------------------------------------------------------------
// flag register layout
// ----------------------------------------------------------------
`define CRS_FLG_C 0
`define CRS_FLG_D 1
`define CRS_FLG_Z 2
`define CRS_FLG_S 3
`define CRS_FLG_B 4
`define CRS_FLG_O 5
`define CRS_FLG_U 7
`define CRS_FLG_RESET 11'h000
`define CRS_VECTB_RESET 20'h00000
`define CRS_IPTR_RESET 20'h00000

// ----------------------------------------------------------------
// memory map bounds
// ----------------------------------------------------------------
`define CRS_SFR0_HI 20'h002FF
`define CRS_RAM_LO 20'h00400
`define CRS_RAM_HI 20'h013FF
`define CRS_SFR1_LO 20'h02C00
`define CRS_SFR1_HI 20'h02FFF
`define CRS_DFL_LO 20'h03000
`define CRS_DFL_HI 20'h03FFF
`define CRS_ROM_LO 20'h04000
`define CRS_ROM_HI 20'h0FFFF
`define CRS_VEC_LO 20'h0FFDC

// ----------------------------------------------------------------
// axi response codes
// ----------------------------------------------------------------
`define CRS_RESP_OKAY 2'h0
`define CRS_RESP_SLVERR 2'h2

`endif

// ===== common/crs_pkg.sv
// types shared by the cpu register set block
`default_nettype none
package crs_pkg;
  // operand size on the core ports
  typedef enum logic [1:0] {
    CRS_SZ_WORD = 2'h0,
    CRS_SZ_LOW = 2'h1,
    CRS_SZ_HIGH = 2'h2,
    CRS_SZ_LONG = 2'h3
  } crs_size_type;
  // memory region seen by the address decoder, one-hot
  typedef enum logic [6:0] {
    CRS_RG_SFR = 7'h01,
    CRS_RG_RAM = 7'h02,
    CRS_RG_DFL = 7'h04,
    CRS_RG_ROM = 7'h08,
    CRS_RG_VEC = 7'h10,
    CRS_RG_EXT = 7'h20,
    CRS_RG_RSV = 7'h40
  } crs_region_type;
  // axi read channel state, one-hot
  typedef enum logic [1:0] {
    CRS_RD_IDLE = 2'h1,
    CRS_RD_DATA = 2'h2
  } crs_rd_state_type;
endpackage
`default_nettype wire

// ===== dv/crs_core_model.sv
// behavioural model of the core sequencer and alu that drive the register set
`include "crs_defs.svh"
`default_nettype none
module crs_core_model
  import crs_pkg::*;
(
  // clock
  input wire logic i_clock,
  // register port requests
  output logic o_wr_en,
  output logic [3:0] o_wr_sel,
  output crs_size_type o_wr_size,
  output logic [31:0] o_wr_data,
  output logic [3:0] o_rd_sel,
  output crs_size_type o_rd_size,
  // alu results
  output logic o_alu_done,
  output logic [31:0] o_alu_result,
  output logic o_alu_long,
  output logic o_alu_carry,
  output logic o_alu_ovf,
  output logic [3:0] o_alu_mask,
  // fetch control and fetch address
  output logic o_ip_load,
  output logic [19:0] o_ip_value,
  output logic [2:0] o_ip_step,
  output logic [19:0] o_mem_addr
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle levels from time zero
  initial
  begin
    {o_wr_en, o_wr_sel, o_wr_data, o_rd_sel, o_alu_done, o_alu_result} = '0;
    {o_alu_long, o_alu_carry, o_alu_ovf, o_alu_mask, o_ip_load, o_ip_value} = '0;
    {o_ip_step, o_mem_addr} = '0;
    o_wr_size = CRS_SZ_WORD;
    o_rd_size = CRS_SZ_WORD;
  end

  // one write cycle; the data lines show garbage once released
  task automatic reg_write(input logic [3:0] sel, input crs_size_type sz,
                           input logic [31:0] val);
    @(posedge i_clock);
    o_wr_en <= 1'b1;
    o_wr_sel <= sel;
    o_wr_size <= sz;
    // software never sets the debug flag
    o_wr_data <= (sel == `CRS_IDX_FLAGS) ? (val & ~32'h2) : val;
    @(posedge i_clock);
    o_wr_en <= 1'b0;
    o_wr_data <= ~val;
  endtask

  // select a register; the result is registered one edge later
  task automatic reg_select(input logic [3:0] sel, input crs_size_type sz);
    @(posedge i_clock);
    o_rd_sel <= sel;
    o_rd_size <= sz;
    @(posedge i_clock);
  endtask

  // one-cycle alu completion pulse
  task automatic alu_op(input logic [31:0] res, input logic lg, input logic c,
                        input logic o, input logic [3:0] m);
    @(posedge i_clock);
    o_alu_done <= 1'b1;
    o_alu_result <= res;
    o_alu_long <= lg;
    o_alu_carry <= c;
    o_alu_ovf <= o;
    o_alu_mask <= m;
    @(posedge i_clock);
    o_alu_done <= 1'b0;
    o_alu_result <= ~res;
  endtask

  // load the pointer, then let it step for a number of edges
  task automatic ip_run(input logic [19:0] val, input logic [2:0] st, input int c);
    @(posedge i_clock);
    o_ip_load <= 1'b1;
    o_ip_value <= val;
    o_ip_step <= st;
    @(posedge i_clock);
    o_ip_load <= 1'b0;
    o_ip_value <= ~val;
    repeat (c) @(posedge i_clock);
    o_ip_step <= 3'h0;
  endtask

  // present one fetch address for decode
  task automatic mem_probe(input logic [19:0] a);
    @(posedge i_clock);
    o_mem_addr <= a;
    @(posedge i_clock);
  endtask
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// self-checking bench for the cpu register set block
`include "crs_defs.svh"
`default_nettype none
module tb_top
  import crs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic i_clock, i_resetn, i_wr_en, i_alu_done, i_alu_long, i_alu_carry, i_alu_ovf, i_ip_load;
  logic [3:0] i_wr_sel, i_rd_sel, i_alu_mask;
  logic [31:0] i_wr_data, i_alu_result, o_rd_data;
  logic [2:0] i_ip_step;
  logic [19:0] i_ip_value, i_mem_addr, o_instr_ptr, o_vector_base;
  logic [15:0] o_active_sp;
  logic [10:0] o_flags;
  crs_size_type i_wr_size, i_rd_size;
  crs_region_type o_mem_region;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_errors = 0;
  int checked = 0;
  int k;
  // decode probes: edges of every window plus the gaps between them
  logic [19:0] map_a [16] = '{20'h00000, 20'h002FF, 20'h00300, 20'h00400, 20'h013FF, 20'h01400,
    20'h02C00, 20'h02FFF, 20'h03000, 20'h03FFF, 20'h04000, 20'h0FFDB, 20'h0FFDC, 20'h0FFFF,
    20'h10000, 20'hFFFFF};
  logic [6:0] map_r [16] = '{7'h01, 7'h01, 7'h40, 7'h02, 7'h02, 7'h40, 7'h01, 7'h01, 7'h04,
    7'h04, 7'h08, 7'h08, 7'h10, 7'h10, 7'h20, 7'h20};

  crs_regset u_dut (
    .i_clock, .i_resetn, .i_wr_en, .i_wr_sel, .i_wr_size, .i_wr_data, .i_rd_sel, .i_rd_size,
    .o_rd_data, .i_alu_done, .i_alu_result, .i_alu_long, .i_alu_carry, .i_alu_ovf, .i_alu_mask,
    .i_ip_load, .i_ip_value, .i_ip_step, .o_instr_ptr, .o_vector_base, .o_active_sp, .o_flags,
    .i_mem_addr, .o_mem_region, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  crs_core_model u_core (
    .i_clock, .o_wr_en(i_wr_en), .o_wr_sel(i_wr_sel), .o_wr_size(i_wr_size),
    .o_wr_data(i_wr_data), .o_rd_sel(i_rd_sel), .o_rd_size(i_rd_size), .o_alu_done(i_alu_done),
    .o_alu_result(i_alu_result), .o_alu_long(i_alu_long), .o_alu_carry(i_alu_carry),
    .o_alu_ovf(i_alu_ovf), .o_alu_mask(i_alu_mask), .o_ip_load(i_ip_load),
    .o_ip_value(i_ip_value), .o_ip_step(i_ip_step), .o_mem_addr(i_mem_addr));

  // 20 MHz clock
  always #25 i_clock = ~i_clock;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // verdict and end of run, the one exit point
  task automatic give_verdict();
    if (n_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // value compare, unknowns never match
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // a wait that ran out ends the run
  task automatic guard(inout int n);
    n++;
    if (n > 40)
    begin
      n_errors++;
      give_verdict();
    end
  endtask

  // axi write; handshakes judged mid-cycle, released after the taking edge
  task automatic axi_wr(input logic [3:0] idx, input logic [31:0] d, input logic [3:0] st,
                        input logic [1:0] er);
    int n;
    logic a, w, b;
    n = 0;
    b = 1'b0;
    @(posedge i_clock);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b)
    begin
      @(negedge i_clock);
      a = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      if (b)
        check(s_axi_bresp, er);
      @(posedge i_clock);
      if (a)
        s_axi_awvalid <= 1'b0;
      if (w)
        s_axi_wvalid <= 1'b0;
      if (b)
        s_axi_bready <= 1'b0;
      guard(n);
    end
    #1;
  endtask

  // axi read with expected data and response
  task automatic axi_rd(input logic [3:0] idx, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic a, r;
    n = 0;
    r = 1'b0;
    @(posedge i_clock);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r)
    begin
      @(negedge i_clock);
      a = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      if (r)
      begin
        check(s_axi_rdata, ed);
        check(s_axi_rresp, er);
      end
      @(posedge i_clock);
      if (a)
        s_axi_arvalid <= 1'b0;
      if (r)
        s_axi_rready <= 1'b0;
      guard(n);
    end
  endtask

  // core port read through the model
  task automatic rd_chk(input logic [3:0] sel, input crs_size_type sz, input logic [31:0] e);
    u_core.reg_select(sel, sz);
    #1 check(o_rd_data, e);
  endtask

  // alu completion, then flag compare
  task automatic alu_chk(input logic [31:0] res, input logic lg, input logic c,
                         input logic o, input logic [3:0] m, input logic [10:0] e);
    u_core.alu_op(res, lg, c, o, m);
    #1 check(o_flags, e);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    {i_clock, i_resetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (3) @(posedge i_clock);
    i_resetn <= 1'b1;
    // everything clears on reset
    for (k = 0; k <= 12; k++)
      axi_rd(k[3:0], 32'h0, `CRS_RESP_OKAY);
    // width of every register; upper bits dropped
    for (k = 0; k <= 12; k++)
    begin
      axi_wr(k[3:0], 32'hFFFFFFFD, 4'hF, `CRS_RESP_OKAY);
      axi_rd(k[3:0], (k == 8 || k == 9) ? 32'hFFFFD : (k == 12) ? 32'h7FD : 32'hFFFD,
             `CRS_RESP_OKAY);
    end
    check(o_vector_base, 32'hFFFFD);
    check(o_active_sp, 32'hFFFD);
    // the flag pattern above left bank 1 selected; go back to bank 0 first
    axi_wr(4'hC, 32'h0, 4'hF, `CRS_RESP_OKAY);
    axi_wr(4'h0, 32'h12, 4'h1, `CRS_RESP_OKAY);
    axi_rd(4'h0, 32'hFF12, `CRS_RESP_OKAY);
    // unmapped index refused and left unwritten
    axi_wr(4'hD, 32'h1234, 4'hF, `CRS_RESP_SLVERR);
    axi_rd(4'hD, 32'h0, `CRS_RESP_SLVERR);
    // stack select
    axi_wr(4'hA, 32'hAAAA, 4'hF, `CRS_RESP_OKAY);
    axi_wr(4'hB, 32'h5555, 4'hF, `CRS_RESP_OKAY);
    axi_wr(4'hC, 32'h0, 4'hF, `CRS_RESP_OKAY);
    check(o_active_sp, 32'hAAAA);
    axi_wr(4'hC, 32'h80, 4'hF, `CRS_RESP_OKAY);
    check(o_active_sp, 32'h5555);
    axi_wr(4'hC, 32'h0, 4'hF, `CRS_RESP_OKAY);
    // byte halves of the first two data registers
    for (k = 0; k <= 1; k++)
    begin
      u_core.reg_write(k[3:0], CRS_SZ_WORD, 32'h1234);
      u_core.reg_write(k[3:0], CRS_SZ_LOW, 32'hAB);
      u_core.reg_write(k[3:0], CRS_SZ_HIGH, 32'hCD);
      rd_chk(k[3:0], CRS_SZ_WORD, 32'hCDAB);
      rd_chk(k[3:0], CRS_SZ_LOW, 32'hAB);
      rd_chk(k[3:0], CRS_SZ_HIGH, 32'hCD);
    end
    // long pairs, higher register holds the upper half
    for (k = 0; k <= 2; k++)
    begin
      u_core.reg_write((k == 2) ? 4'h4 : k[3:0], CRS_SZ_LONG, 32'h89ABCDEF);
      rd_chk((k == 2) ? 4'h4 : k[3:0], CRS_SZ_LONG, 32'h89ABCDEF);
      rd_chk((k == 2) ? 4'h5 : k[3:0] + 4'h2, CRS_SZ_WORD, 32'h89AB);
    end
    // bank switch redirects the data registers
    u_core.reg_write(4'h0, CRS_SZ_WORD, 32'h1111);
    u_core.reg_write(4'hC, CRS_SZ_WORD, 32'h10);
    u_core.reg_write(4'h0, CRS_SZ_WORD, 32'h2222);
    rd_chk(4'h0, CRS_SZ_WORD, 32'h2222);
    u_core.reg_write(4'hC, CRS_SZ_WORD, 32'h0);
    rd_chk(4'h0, CRS_SZ_WORD, 32'h1111);
    // flag updates, masked flags keep their value
    alu_chk(32'h0, 1'b0, 1'b1, 1'b0, 4'hF, 11'h005);
    alu_chk(32'h8000, 1'b0, 1'b0, 1'b1, 4'hF, 11'h028);
    alu_chk(32'h0, 1'b0, 1'b1, 1'b0, 4'h1, 11'h029);
    alu_chk(32'h10000, 1'b1, 1'b0, 1'b0, 4'hF, 11'h000);
    alu_chk(32'h10000, 1'b0, 1'b0, 1'b0, 4'hF, 11'h004);
    alu_chk(32'h80000000, 1'b1, 1'b0, 1'b0, 4'h4, 11'h00C);
    // pointer load and step, with wrap at the top
    u_core.ip_run(20'h12345, 3'h3, 5);
    #1 check(o_instr_ptr, 32'h12354);
    u_core.ip_run(20'hFFFFE, 3'h3, 1);
    #1 check(o_instr_ptr, 32'h00001);
    // address decode across the whole space
    for (k = 0; k < 16; k++)
    begin
      u_core.mem_probe(map_a[k]);
      #1 check(o_mem_region, map_r[k]);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
